// >>> vdsrp_pkg.sv
// shared constants and types for the video decoder serial register port
// assumes one importing design file and a register bank of fixed size
package vdsrp_pkg;

   // subaddress space: entries 0 .. highest are valid, limit is the first bad one
   localparam int unsigned REG_COUNT   = 71;
   localparam logic [7:0]  PTR_HIGHEST = 8'h46;
   localparam logic [7:0]  PTR_LIMIT   = 8'h47;
   localparam logic [7:0]  PTR_RESET   = 8'h00;
   localparam logic [7:0]  REG_RESET   = 8'h00;

   // slave address: six fixed upper bits, lowest bit from the strap pin
   localparam logic [5:0]  SLAVE_ADDR_HI = 6'h22;
   localparam logic        RW_READ       = 1'b1;
   localparam logic        LINE_ACK      = 1'b0;

   // pulse counter marks within one byte frame
   localparam logic [3:0]  BIT_FIRST = 4'h0;
   localparam logic [3:0]  BIT_LAST  = 4'h7;
   localparam logic [3:0]  BIT_ACK   = 4'h8;
   localparam logic [3:0]  BIT_STEP  = 4'h1;
   localparam logic [7:0]  PTR_STEP  = 8'h01;

   // register offsets of the basic block
   localparam logic [7:0]  OFS_INPUT_SOURCE_SELECT   = 8'h00;
   localparam logic [7:0]  OFS_VIDEO_STANDARD_SELECT = 8'h01;
   localparam logic [7:0]  OFS_PICTURE_ENHANCE_CTL   = 8'h02;
   localparam logic [7:0]  OFS_OUTPUT_FORMAT_CTL     = 8'h03;
   localparam logic [7:0]  OFS_OUTPUT_EXTRA_CTL      = 8'h04;
   localparam logic [7:0]  OFS_SPARE_PIN_OUTPUT      = 8'h05;
   localparam logic [7:0]  OFS_RESERVED_SLOT_06      = 8'h06;
   localparam logic [7:0]  OFS_FIFO_CTL              = 8'h07;
   localparam logic [7:0]  OFS_CONTRAST_LEVEL        = 8'h08;
   localparam logic [7:0]  OFS_SATURATION_LEVEL      = 8'h09;
   localparam logic [7:0]  OFS_BRIGHTNESS_LEVEL      = 8'h0a;
   localparam logic [7:0]  OFS_HUE_ADJUST            = 8'h0b;
   localparam logic [7:0]  OFS_FALLBACK_LUMA_VALUE   = 8'h0c;
   localparam logic [7:0]  OFS_FALLBACK_CHROMA_VALUE = 8'h0d;
   localparam logic [7:0]  OFS_FRAME_DROP_CTL        = 8'h0e;
   localparam logic [7:0]  OFS_POWER_CTL             = 8'h0f;
   localparam logic [7:0]  OFS_DECODER_STATE         = 8'h10;
   localparam logic [7:0]  OFS_PART_INFO             = 8'h11;

   // link engine phases
   typedef enum logic [2:0] {
      st_idle,
      st_addr,
      st_sub,
      st_wdata,
      st_rdata
   } vdsrp_state_t;

   typedef logic [REG_COUNT-1:0][7:0] vdsrp_bank_t;

   // one byte write handed from the link side to the bank side
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] data;
   } vdsrp_wr_t;

endpackage

// >>> vdsrp_serial_port.sv
// two-wire serial slave port giving a host access to the decoder register bank
// assumes serial_clock_line is the link clock and the pad logic resolves the data wire
//
// Behaviour
// - answer a 7-bit slave address whose lowest bit follows the strap pin
// - lowest bit of the first byte picks read (1) or write (0)
// - a start is data falling while the serial clock is high
// - eight bits follow a start, most significant bit first
// - on an address match, pull data low during the ninth clock pulse
// - on a mismatch, release the bus and wait for the next start
// - first byte is the slave address, second byte of a write is the starting subaddress
// - seventy-one subaddress locations reach the internal registers
// - pointer advances by one after every data byte read or written, except reads at the highest register
// - a stop anywhere sends the engine straight to idle; a start anywhere restarts the address phase
// - invalid subaddress gets no acknowledge and the port goes idle
// - reads past the top keep returning the highest register until no-acknowledge
// - writes past the top are dropped, not acknowledged, and the port idles
// - registers read and write, except the reserved slot (reads zero) and the decoder state (reads live status); the pointer itself is write-only
// - pointer is eight bits, loaded whole from the subaddress byte; values of 0x47 and up are refused
`timescale 1ns/1ps
`default_nettype none

module vdsrp_serial_port (
   input  wire logic                 clock,
   input  wire logic                 sys_rst,
   input  wire logic                 serial_clock_line,
   input  wire logic                 serial_data_line_i,
   input  wire logic                 addr_low_bit_pin,
   input  wire logic [7:0]           decoder_status,
   output logic                      serial_data_line_o,
   output logic                      serial_data_line_oe_n,
   output vdsrp_pkg::vdsrp_bank_t    reg_image
);
   import vdsrp_pkg::*;

   // ---------------- link domain (serial clock) ----------------

   logic                link_hold_q;
   logic                hold_ack_meta_q;
   logic                hold_ack_q;
   logic                eng_rst_q;
   logic                link_rst_meta_q;
   logic                link_rst_q;
   logic                strap_meta_q;
   logic                pin_set_addr_bit;
   logic                sda_rise_q;
   logic [7:0]          rx_q;
   vdsrp_state_t        state_q;
   vdsrp_state_t        state_d;
   logic [3:0]          cnt_q;
   logic [3:0]          cnt_d;
   logic [7:0]          ptr_q;
   logic [7:0]          ptr_d;
   logic [7:0]          tx_q;
   logic [7:0]          tx_d;
   logic                oe_n_q;
   logic                oe_n_d;
   logic                sda_o_q;
   logic                wr_go;
   logic                ptr_go;
   logic                wr_tgl_q;
   logic                ptr_tgl_q;
   vdsrp_wr_t           wr_q;
   logic [7:0]          rd_byte_q;

   // reset and strap cross into the link domain through two flops each;
   // the link clock may stand still, so the reset request is held until the engine reports it
   always_ff @(posedge serial_clock_line) begin
      link_rst_meta_q <= link_hold_q;
      link_rst_q      <= link_rst_meta_q;
      strap_meta_q    <= addr_low_bit_pin;
      pin_set_addr_bit <= strap_meta_q;
   end

   // data is sampled on the rising clock edge, msb first
   always_ff @(posedge serial_clock_line) begin
      if (link_rst_q) begin
         sda_rise_q <= 1'b1;
         rx_q       <= REG_RESET;
      end else begin
         sda_rise_q <= serial_data_line_i;
         rx_q       <= {rx_q[6:0], serial_data_line_i};
      end
   end

   // data must hold through the high phase, so any change seen at the
   // falling edge was a start or a stop; stop-then-start in one high
   // with low data at both edges reads as no event
   wire start_det = sda_rise_q & ~serial_data_line_i;
   wire stop_det  = ~sda_rise_q & serial_data_line_i;

   // address, subaddress and pointer decoding
   wire       addr_match  = (rx_q[7:1] == {SLAVE_ADDR_HI, pin_set_addr_bit});
   wire       dir_read    = (rx_q[0] == RW_READ);
   wire       sub_valid   = (rx_q < PTR_LIMIT);
   wire       ptr_ok      = (ptr_q < PTR_LIMIT);
   wire       master_ack  = (rx_q[0] == LINE_ACK);
   wire [7:0] ptr_inc     = ptr_q + PTR_STEP;
   wire [7:0] ptr_rd_next = (ptr_q >= PTR_HIGHEST) ? PTR_HIGHEST : ptr_inc;
   wire [3:0] cnt_next    = (cnt_q == BIT_ACK) ? BIT_FIRST : cnt_q + BIT_STEP;

   // byte engine: decisions are made on the falling clock edge so the
   // data line changes only while the clock is low
   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_next;
      ptr_d   = ptr_q;
      tx_d    = tx_q;
      oe_n_d  = oe_n_q;
      wr_go   = 1'b0;
      ptr_go  = 1'b0;
      if (start_det) begin
         state_d = st_addr;
         cnt_d   = BIT_FIRST;
         oe_n_d  = 1'b1;
      end else if (stop_det) begin
         state_d = st_idle;
         cnt_d   = BIT_FIRST;
         oe_n_d  = 1'b1;
      end else begin
         case (state_q)
            st_idle: begin
               cnt_d  = BIT_FIRST;
               oe_n_d = 1'b1;
            end
            st_addr: begin
               if (cnt_q == BIT_LAST) begin
                  if (addr_match) begin
                     oe_n_d  = 1'b0;
                     state_d = dir_read ? st_rdata : st_sub;
                  end else begin
                     oe_n_d  = 1'b1;
                     state_d = st_idle;
                  end
               end
            end
            st_sub: begin
               if (cnt_q == BIT_LAST) begin
                  if (sub_valid) begin
                     oe_n_d  = 1'b0;
                     ptr_d   = rx_q;
                     ptr_go  = 1'b1;
                     state_d = st_wdata;
                  end else begin
                     oe_n_d  = 1'b1;
                     state_d = st_idle;
                  end
               end else if (cnt_q == BIT_ACK) begin
                  oe_n_d = 1'b1;
               end
            end
            st_wdata: begin
               if (cnt_q == BIT_LAST) begin
                  if (ptr_ok) begin
                     oe_n_d = 1'b0;
                     wr_go  = 1'b1;
                     ptr_d  = ptr_inc;
                     ptr_go = 1'b1;
                  end else begin
                     oe_n_d  = 1'b1;
                     state_d = st_idle;
                  end
               end else if (cnt_q == BIT_ACK) begin
                  oe_n_d = 1'b1;
               end
            end
            st_rdata: begin
               if (cnt_q < BIT_LAST) begin
                  tx_d   = {tx_q[6:0], 1'b0};
                  oe_n_d = tx_q[6];
               end else if (cnt_q == BIT_LAST) begin
                  oe_n_d = 1'b1;
               end else if (master_ack) begin
                  tx_d   = rd_byte_q;
                  oe_n_d = rd_byte_q[7];
                  ptr_d  = ptr_rd_next;
                  ptr_go = 1'b1;
               end else begin
                  oe_n_d  = 1'b1;
                  state_d = st_idle;
               end
            end
            default: begin
               state_d = st_idle;
               oe_n_d  = 1'b1;
            end
         endcase
      end
   end

   // engine registers; the write request word is held until the next
   // byte, far longer than the bank side needs to take it
   always_ff @(negedge serial_clock_line) begin
      if (link_rst_q) begin
         state_q   <= st_idle;
         cnt_q     <= BIT_FIRST;
         ptr_q     <= PTR_RESET;
         tx_q      <= REG_RESET;
         oe_n_q    <= 1'b1;
         sda_o_q   <= 1'b0;
         wr_tgl_q  <= 1'b0;
         ptr_tgl_q <= 1'b0;
         eng_rst_q <= 1'b1;
         wr_q      <= '{addr: PTR_RESET, data: REG_RESET};
      end else begin
         state_q   <= state_d;
         cnt_q     <= cnt_d;
         ptr_q     <= ptr_d;
         tx_q      <= tx_d;
         oe_n_q    <= oe_n_d;
         sda_o_q   <= 1'b0;
         wr_tgl_q  <= wr_tgl_q ^ wr_go;
         ptr_tgl_q <= ptr_tgl_q ^ ptr_go;
         eng_rst_q <= 1'b0;
         if (wr_go) begin
            wr_q <= '{addr: ptr_q, data: rx_q};
         end
      end
   end

   // open-drain pad: level is always low, enable low means pulled down
   assign serial_data_line_o    = sda_o_q;
   assign serial_data_line_oe_n = oe_n_q;

   // ---------------- bank domain (system clock) ----------------

   logic                wr_meta_q;
   logic                wr_sync_q;
   logic                wr_last_q;
   logic                ptr_meta_q;
   logic                ptr_sync_q;
   logic                ptr_last_q;
   logic [7:0]          ptr_seen_q;
   vdsrp_bank_t         bank_q;

   // link reset request: the serial clock may stand still during sys_rst,
   // so the request is held until the engine reports that it was reset
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         link_hold_q     <= 1'b1;
         hold_ack_meta_q <= 1'b0;
         hold_ack_q      <= 1'b0;
      end else begin
         hold_ack_meta_q <= eng_rst_q;
         hold_ack_q      <= hold_ack_meta_q;
         if (hold_ack_q) begin
            link_hold_q <= 1'b0;
         end
      end
   end

   // toggle crossings; the second and third stages feed the edge detect;
   // held while the link is unreset, so stale toggles make no false write
   always_ff @(posedge clock) begin
      if (sys_rst || link_hold_q) begin
         wr_meta_q  <= 1'b0;
         wr_sync_q  <= 1'b0;
         wr_last_q  <= 1'b0;
         ptr_meta_q <= 1'b0;
         ptr_sync_q <= 1'b0;
         ptr_last_q <= 1'b0;
      end else begin
         wr_meta_q  <= wr_tgl_q;
         wr_sync_q  <= wr_meta_q;
         wr_last_q  <= wr_sync_q;
         ptr_meta_q <= ptr_tgl_q;
         ptr_sync_q <= ptr_meta_q;
         ptr_last_q <= ptr_sync_q;
      end
   end

   wire wr_edge  = wr_sync_q ^ wr_last_q;
   wire ptr_edge = ptr_sync_q ^ ptr_last_q;

   // pointer copy for read lookup; the link word is stable once toggled
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         ptr_seen_q <= PTR_RESET;
      end else if (ptr_edge) begin
         ptr_seen_q <= ptr_q;
      end
   end

   // read selection: past the top the highest entry repeats, the state
   // register shows live decoder status, the reserved slot reads zero
   wire [7:0] rd_idx = (ptr_seen_q >= PTR_LIMIT) ? PTR_HIGHEST : ptr_seen_q;
   wire [7:0] rd_sel = (rd_idx == OFS_DECODER_STATE)    ? decoder_status :
                       (rd_idx == OFS_RESERVED_SLOT_06) ? REG_RESET :
                       bank_q[rd_idx];

   // read byte is refreshed every cycle; the link loads it a full byte
   // time after the pointer moved, which bounds the fastest serial clock
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         rd_byte_q <= REG_RESET;
      end else begin
         rd_byte_q <= rd_sel;
      end
   end

   // register bank, one entry per subaddress
   genvar g;
   generate
      for (g = 0; g < REG_COUNT; g = g + 1) begin : gen_bank
         wire hit = wr_edge && (wr_q.addr == 8'(g)) && (8'(g) != OFS_RESERVED_SLOT_06);
         always_ff @(posedge clock) begin
            if (sys_rst) begin
               bank_q[g] <= REG_RESET;
            end else if (hit) begin
               bank_q[g] <= wr_q.data;
            end
         end
      end
   endgenerate

   assign reg_image = bank_q;

   // ---------------- checks ----------------

   ack_on_match_a: assert property (
      @(negedge serial_clock_line) disable iff (link_rst_q)
      (state_q == st_addr && cnt_q == BIT_LAST && addr_match && !start_det && !stop_det)
      |=> (!oe_n_q && cnt_q == BIT_ACK) ##1 (state_q != st_addr))
      else $error("address match not acknowledged on ninth pulse");

   mismatch_release_a: assert property (
      @(negedge serial_clock_line) disable iff (link_rst_q)
      (state_q == st_addr && cnt_q == BIT_LAST && !addr_match && !start_det && !stop_det)
      |=> (state_q == st_idle && oe_n_q))
      else $error("mismatched address did not release the bus");

   start_rearm_a: assert property (
      @(negedge serial_clock_line) disable iff (link_rst_q)
      start_det |=> (state_q == st_addr && cnt_q == BIT_FIRST && oe_n_q))
      else $error("start did not restart the address phase");

   stop_idle_a: assert property (
      @(negedge serial_clock_line) disable iff (link_rst_q)
      (stop_det && !start_det) |=> (state_q == st_idle && oe_n_q))
      else $error("stop did not return the port to idle");

   bad_sub_nack_a: assert property (
      @(negedge serial_clock_line) disable iff (link_rst_q)
      (state_q == st_sub && cnt_q == BIT_LAST && !sub_valid && !start_det && !stop_det)
      |=> (state_q == st_idle && oe_n_q && $stable(ptr_q)))
      else $error("invalid subaddress was acknowledged");

   wr_overrun_a: assert property (
      @(negedge serial_clock_line) disable iff (link_rst_q)
      (state_q == st_wdata && cnt_q == BIT_LAST && !ptr_ok && !start_det && !stop_det)
      |=> (state_q == st_idle && oe_n_q && $stable(wr_tgl_q)))
      else $error("overflowing write byte was not dropped");

   wr_step_a: assert property (
      @(negedge serial_clock_line) disable iff (link_rst_q)
      (state_q == st_wdata && cnt_q == BIT_LAST && ptr_ok && !start_det && !stop_det)
      |=> (ptr_q == $past(ptr_q) + PTR_STEP && wr_q.addr == $past(ptr_q) && wr_tgl_q != $past(wr_tgl_q)))
      else $error("write byte did not advance the pointer by one");

   rd_ceiling_a: assert property (
      @(negedge serial_clock_line) disable iff (link_rst_q)
      (state_q == st_rdata && cnt_q == BIT_ACK && master_ack && ptr_q >= PTR_HIGHEST && !start_det && !stop_det)
      |=> (ptr_q == PTR_HIGHEST))
      else $error("read pointer passed the highest subaddress");

   rd_ack_release_a: assert property (
      @(negedge serial_clock_line) disable iff (link_rst_q)
      (state_q == st_rdata && cnt_q == BIT_LAST && !start_det && !stop_det)
      |=> (oe_n_q && cnt_q == BIT_ACK))
      else $error("data line held during master acknowledge");

   bank_commit_a: assert property (
      @(posedge clock) disable iff (sys_rst)
      (wr_edge && wr_q.addr < PTR_LIMIT && wr_q.addr != OFS_RESERVED_SLOT_06)
      |=> (bank_q[$past(wr_q.addr)] == $past(wr_q.data)))
      else $error("received byte not stored in the bank");

   ptr_follow_a: assert property (
      @(posedge clock) disable iff (sys_rst)
      ptr_edge |=> (ptr_seen_q == $past(ptr_q)) ##1 (rd_byte_q == $past(rd_sel)))
      else $error("bank side pointer did not follow the link");

endmodule
`default_nettype wire

// >>> vdsrp_bus_master.sv
// behavioural two-wire bus master that drives the serial register port
// assumes an open-drain data wire with a pull-up, resolved by the bench
`timescale 1ns/1ps
`default_nettype none

module vdsrp_bus_master (
   output logic       serial_clock_line,
   output logic       sda_pull_low,
   input  wire logic  sda_line,
   output logic       got_stb,
   output logic [8:0] got_val
);
   localparam real QTR = 40.0;

   // clock rests high between frames and the data wire is released
   initial begin
      serial_clock_line = 1'b1;
      sda_pull_low      = 1'b0;
      got_stb           = 1'b0;
      got_val           = 9'h000;
   end

   // one clock pulse; data only changes while the clock is low
   task automatic bit_io(input logic drive_low, output logic seen);
      sda_pull_low = drive_low;
      #QTR serial_clock_line = 1'b1;
      #QTR seen = sda_line;
      #QTR serial_clock_line = 1'b0;
      #QTR;
   endtask

   // data falls while the clock is high
   task automatic start_cond();
      serial_clock_line = 1'b0;
      sda_pull_low      = 1'b0;
      #QTR serial_clock_line = 1'b1;
      #QTR sda_pull_low = 1'b1;
      #QTR serial_clock_line = 1'b0;
      #QTR;
   endtask

   // data rises while the clock is high, then the clock stands still
   task automatic stop_cond();
      sda_pull_low = 1'b1;
      #QTR serial_clock_line = 1'b1;
      #QTR sda_pull_low = 1'b0;
      #(2 * QTR);
   endtask

   // idle pulses with data released, no start can be seen
   task automatic pulses(input int n);
      logic s;
      for (int i = 0; i < n; i++) bit_io(1'b0, s);
   endtask

   // hand the bench what came back from one byte frame
   task automatic report(input logic [8:0] v);
      got_val = v;
      got_stb = 1'b1;
      #1 got_stb = 1'b0;
   endtask

   // send a byte msb first, then release data for the device acknowledge
   task automatic put_byte(input logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(!b[i], s);
      bit_io(1'b0, s);
      report({8'h00, !s});
   endtask

   // receive a byte; a no-acknowledge leaves data high on the ninth pulse
   task automatic get_byte(input logic ack, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b0, s);
         b[i] = s;
      end
      bit_io(ack, s);
      report({1'b1, b});
   endtask
endmodule

`default_nettype wire

// >>> test_vdsrp_serial_port.sv
// self-checking bench for the serial register port, master model on the link
// assumes the package constants and a pull-up on the data wire
`timescale 1ns/1ps
`default_nettype none

module test_vdsrp_serial_port;
   import vdsrp_pkg::*;
   logic        clock;
   logic        sys_rst;
   logic        addr_low_bit_pin;
   logic [7:0]  decoder_status;
   logic        serial_data_line_o;
   logic        serial_data_line_oe_n;
   vdsrp_bank_t reg_image;
   wire logic   serial_clock_line;
   wire logic   sda_pull_low;
   wire logic   got_stb;
   wire logic [8:0] got_val;
   wire logic   sda_line = !sda_pull_low && serial_data_line_oe_n;
   logic [8:0]  exp_q[$];
   logic [7:0]  shadow[REG_COUNT];
   int          n_errors = 0;
   int          samples_checked = 0;
   integer      seed = 32'h166e;
   logic        s;

   vdsrp_serial_port DUT (.clock(clock), .sys_rst(sys_rst), .serial_clock_line(serial_clock_line),
      .serial_data_line_i(sda_line), .addr_low_bit_pin(addr_low_bit_pin),
      .decoder_status(decoder_status), .serial_data_line_o(serial_data_line_o),
      .serial_data_line_oe_n(serial_data_line_oe_n), .reg_image(reg_image));
   vdsrp_bus_master u_master (.serial_clock_line(serial_clock_line), .sda_pull_low(sda_pull_low),
      .sda_line(sda_line), .got_stb(got_stb), .got_val(got_val));

   // 40 MHz system clock
   always #12.5 clock = !clock;

   task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // every byte frame result is matched against the oldest note
   always @(posedge got_stb) begin
      if (exp_q.size() == 0) chk(got_val, 9'h1ff);
      else chk(got_val, exp_q.pop_front());
   end

   // expected read value; the pointer sticks at the top entry
   function automatic logic [7:0] rexp(input int a);
      int b;
      b = (a > PTR_HIGHEST) ? PTR_HIGHEST : a;
      if (b == OFS_RESERVED_SLOT_06) return 8'h00;
      if (b == OFS_DECODER_STATE) return decoder_status;
      return shadow[b];
   endfunction

   task automatic addr(input logic strap, input logic rd_n, input logic ack);
      u_master.start_cond();
      exp_q.push_back({8'h00, ack});
      u_master.put_byte({SLAVE_ADDR_HI, strap, rd_n});
   endtask

   task automatic wr(input logic [7:0] b, input logic ack);
      exp_q.push_back({8'h00, ack});
      u_master.put_byte(b);
   endtask

   task automatic rd(input logic [7:0] e, input logic last);
      logic [7:0] b;
      exp_q.push_back({1'b1, e});
      u_master.get_byte(!last, b);
   endtask

   // first byte addresses the device, second loads the pointer
   task automatic setptr(input logic [7:0] sub, input logic ok);
      addr(addr_low_bit_pin, 1'b0, 1'b1);
      wr(sub, ok);
   endtask

   task automatic wburst(input logic [7:0] sub, input int n);
      logic [7:0] v;
      int a;
      setptr(sub, 1'b1);
      for (int k = 0; k < n; k++) begin
         v = 8'($random(seed));
         a = sub + k;
         wr(v, a < REG_COUNT);
         if (a >= REG_COUNT) break;
         if (a != OFS_RESERVED_SLOT_06) shadow[a] = v;
      end
      u_master.stop_cond();
   endtask

   task automatic rburst(input logic [7:0] sub, input int n);
      setptr(sub, 1'b1);
      u_master.stop_cond();
      addr(addr_low_bit_pin, 1'b1, 1'b1);
      for (int k = 0; k < n; k++) rd(rexp(sub + k), k == n - 1);
      u_master.stop_cond();
   endtask

   // whole bank against the expected image, after the crossing settles
   task automatic bank_chk();
      repeat (6) @(negedge clock);
      for (int a = 0; a < REG_COUNT; a++) chk({1'b0, reg_image[a]}, {1'b0, shadow[a]});
      chk({8'h00, serial_data_line_o}, 9'h000);
   endtask

   // hang guard, well beyond the expected run of about a hundred and twenty microseconds
   initial begin
      #1_000_000;
      n_errors++;
      end_sim();
   end

   // main sequence
   initial begin
      clock = 1'b0;
      sys_rst = 1'b1;
      addr_low_bit_pin = 1'b0;
      decoder_status = 8'h00;
      for (int a = 0; a < REG_COUNT; a++) shadow[a] = 8'h00;
      repeat (12) @(negedge clock);
      sys_rst = 1'b0;
      decoder_status = 8'($random(seed));
      // the link engine only leaves reset once the serial clock has run
      u_master.pulses(8);
      bank_chk();
      wburst(8'h08, 3);
      bank_chk();
      rburst(8'h08, 3);
      wburst(8'h05, 3);
      rburst(8'h05, 3);
      wburst(8'h44, 4);
      bank_chk();
      rburst(8'h0f, 2);
      rburst(8'h45, 4);
      // bad pointers are refused and the port stays idle after them
      for (int i = 0; i < 3; i++) begin
         setptr((i == 0) ? 8'h47 : ((i == 1) ? 8'hc0 : 8'hff), 1'b0);
         wr(8'h5a, 1'b0);
         u_master.stop_cond();
      end
      bank_chk();
      // both strap levels, and the other address must be ignored
      for (int k = 1; k >= 0; k--) begin
         @(negedge clock) addr_low_bit_pin = k[0];
         u_master.pulses(3);
         wburst(8'h20, 2);
         rburst(8'h20, 2);
         addr(!addr_low_bit_pin, 1'b0, 1'b0);
         wr(8'h21, 1'b0);
         u_master.stop_cond();
      end
      // a start in mid data byte aborts the write
      setptr(8'h30, 1'b1);
      for (int k = 0; k < 4; k++) u_master.bit_io(1'b0, s);
      wburst(8'h31, 1);
      bank_chk();
      chk({8'h00, exp_q.size() == 0}, 9'h001);
      end_sim();
   end
endmodule

`default_nettype wire
